// ===== include/fldb_pkg.sv
// package: constants and types for the frequency level detect and brake block
package fldb_pkg;
  localparam int FREQ_W = 16;
  localparam int VOLT_W = 16;
  localparam int PCT_W  = 10;
  // bus register byte offsets
  localparam logic [7:0] OFF_LEVEL_A     = 8'h00;
  localparam logic [7:0] OFF_LAG_A       = 8'h04;
  localparam logic [7:0] OFF_LEVEL_B     = 8'h08;
  localparam logic [7:0] OFF_LAG_B       = 8'h0C;
  localparam logic [7:0] OFF_REACH_W     = 8'h10;
  localparam logic [7:0] OFF_BRAKE_EN    = 8'h14;
  localparam logic [7:0] OFF_BRAKE_THR   = 8'h18;
  localparam logic [7:0] OFF_MAX_FREQ    = 8'h1C;
  localparam logic [7:0] OFF_VCLASS      = 8'h20;
  localparam logic [7:0] OFF_STATUS      = 8'h24;
  localparam logic [7:0] OFF_INT_STAT    = 8'h28;
  localparam logic [7:0] OFF_INT_EN      = 8'h2C;
  localparam logic [7:0] OFF_INT_CLR     = 8'h30;
  // reset values, frequency in 0.01 Hz, voltage in 0.1 V, percent in 0.1 %
  localparam logic [FREQ_W-1:0] LEVEL_DEF    = 16'h1388; // 50.00 Hz
  localparam logic [PCT_W-1:0]  LAG_DEF      = 10'h032;  // 5.0 %
  localparam logic [PCT_W-1:0]  LAG_MAX      = 10'h3E8;  // 100.0 %
  localparam logic [FREQ_W-1:0] REACH_DEF    = 16'h0000;
  localparam logic [FREQ_W-1:0] MAX_FREQ_DEF = 16'h1388; // 50.00 Hz
  localparam logic [VOLT_W-1:0] THR_MIN      = 16'h07D0; // 200.0 V
  localparam logic [VOLT_W-1:0] THR_MAX      = 16'h4E20; // 2000.0 V
  localparam logic [VOLT_W-1:0] THR_220      = 16'h0ED8; // 380.0 V
  localparam logic [VOLT_W-1:0] THR_380      = 16'h1B58; // 700.0 V
  localparam logic [VOLT_W-1:0] THR_660      = 16'h2BC0; // 1120.0 V
  localparam int PCT_SCALE = 1000;
  typedef enum logic [1:0] {
    FLDB_CLASS_220 = 2'h0,
    FLDB_CLASS_380 = 2'h1,
    FLDB_CLASS_660 = 2'h2
  } fldb_vclass_t;
  // status and interrupt bit positions
  localparam int BIT_FLAG_A  = 0;
  localparam int BIT_FLAG_B  = 1;
  localparam int BIT_REACHED = 2;
  localparam int BIT_BRAKE   = 3;
  localparam int N_EVT       = 4;
endpackage

// ===== include/fldb_det_if.sv
// interface: settings and result of one frequency level detector
`timescale 1ns/10ps
interface fldb_det_if;
  logic [fldb_pkg::FREQ_W-1:0] level;
  logic [fldb_pkg::PCT_W-1:0]  lag_pct;
  logic                        flag;
  modport ctrl (output level, output lag_pct, input flag);
  modport det  (input level, input lag_pct, output flag);
endinterface

// ===== hw/fldb_sync.sv
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module fldb_sync #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // s1_r is metastable-prone, so only s2_r reads it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a new word counts only once two stages agree, so torn multi-bit samples drop out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (s2_r == s3_r)
      q <= s3_r;
  end
endmodule

// ===== hw/fldb_level_det.sv
// module: one frequency level detector with percentage hysteresis
`timescale 1ns/10ps
module fldb_level_det (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [fldb_pkg::FREQ_W-1:0] out_freq,
  fldb_det_if.det                          cfg
);
  localparam int PROD_W = fldb_pkg::FREQ_W + fldb_pkg::PCT_W;
  logic [PROD_W-1:0]           lag_prod;
  logic [fldb_pkg::FREQ_W-1:0] lag_amt;
  logic [fldb_pkg::FREQ_W-1:0] low_lvl;

  // lag is a share of this detector's own level; truncation makes the band a hair narrower
  assign lag_prod = PROD_W'(cfg.level) * PROD_W'(cfg.lag_pct);
  assign lag_amt  = fldb_pkg::FREQ_W'(lag_prod / PROD_W'(fldb_pkg::PCT_SCALE)); // RULE3
  assign low_lvl  = cfg.level - lag_amt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg.flag <= 1'b0;
    else if (out_freq > cfg.level)
      cfg.flag <= 1'b1; // RULE1
    else if (out_freq < low_lvl)
      cfg.flag <= 1'b0; // RULE2
  end
endmodule

// ===== hw/fldb_top.sv
// module: frequency level detect, frequency reached and dynamic brake control
`timescale 1ns/10ps
// Behaviour
// RULE1: each level flag stays high while output frequency is above its level.
// RULE2: a level flag drops only when frequency falls below level minus lag.
// RULE3: lag amount is a 0.0 to 100.0 percent share of that level, default 5.0 percent.
// RULE4: a detector level is limited to the range zero to the maximum output frequency; clamped on write only, not when the maximum is lowered later.
// RULE5: a second detector with its own level, default 50.00 Hz, and lag drives its own flag.
// RULE6: reached flag is high while output frequency is within the width of the set frequency.
// RULE7: when enabled, braking starts once bus voltage reaches a 200.0 to 2000.0 V threshold.
// RULE8: threshold default is 380.0, 700.0 or 1120.0 V for the 220, 380 or 660 V class.
// RULE9: all comparisons run every clock in 0.01 Hz and 0.1 V units with clocked flags.
module fldb_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [fldb_pkg::FREQ_W-1:0] out_freq,
  input  wire logic [fldb_pkg::FREQ_W-1:0] set_freq,
  input  wire logic [fldb_pkg::VOLT_W-1:0] bus_volt,
  output logic                             freq_level_flag_a,
  output logic                             freq_level_flag_b,
  output logic                             freq_reached_flag,
  output logic                             brake_on,
  output logic                             irq
);
  localparam int FW = fldb_pkg::FREQ_W;
  localparam int VW = fldb_pkg::VOLT_W;
  localparam int PW = fldb_pkg::PCT_W;

  fldb_det_if det_a ();
  fldb_det_if det_b ();

  logic [FW-1:0]             level_a_setting_r;
  logic [PW-1:0]             lag_a_setting_r;
  logic [FW-1:0]             level_b_setting_r;
  logic [PW-1:0]             lag_b_setting_r;
  logic [FW-1:0]             reached_width_setting_r;
  logic                      brake_enable_setting_r;
  logic [VW-1:0]             brake_threshold_setting_r;
  logic [FW-1:0]             max_output_freq_setting_r;
  logic [1:0]                vclass_r;
  logic                      thr_touched_r;
  logic [fldb_pkg::N_EVT-1:0] int_stat_r;
  logic [fldb_pkg::N_EVT-1:0] int_en_r;
  logic [fldb_pkg::N_EVT-1:0] flags_prev_r;
  logic [fldb_pkg::N_EVT-1:0] flags;
  logic [fldb_pkg::N_EVT-1:0] evt_rise;
  logic [fldb_pkg::N_EVT-1:0] clr_mask;
  logic [FW-1:0]             out_freq_s;
  logic [FW-1:0]             set_freq_s;
  logic [VW-1:0]             bus_volt_s;
  logic [VW-1:0]             class_thr;
  logic [VW-1:0]             eff_thr;
  logic [FW-1:0]             wr_freq;
  logic [FW-1:0]             wr_freq_lim;
  logic [PW-1:0]             wr_pct_lim;
  logic [VW-1:0]             wr_volt;
  logic [VW-1:0]             wr_volt_lim;
  logic [FW:0]               reach_hi;
  logic [FW-1:0]             reach_lo;
  logic                      wr_en;
  logic                      rd_en;
  logic                      addr_ok;
  logic                      freq_reached_nxt;
  logic                      brake_nxt;

  // pins from the drive's measurement path arrive unsynchronised
  fldb_sync #(.W(FW)) u_sync_out (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (out_freq),
    .q       (out_freq_s)
  );
  fldb_sync #(.W(FW)) u_sync_set (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (set_freq),
    .q       (set_freq_s)
  );
  fldb_sync #(.W(VW)) u_sync_volt (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (bus_volt),
    .q       (bus_volt_s)
  );

  assign det_a.level   = level_a_setting_r;
  assign det_a.lag_pct = lag_a_setting_r;
  assign det_b.level   = level_b_setting_r;
  assign det_b.lag_pct = lag_b_setting_r;

  fldb_level_det u_det_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .out_freq (out_freq_s),
    .cfg      (det_a)
  );
  fldb_level_det u_det_b ( // RULE5
    .pclk     (pclk),
    .presetn  (presetn),
    .out_freq (out_freq_s),
    .cfg      (det_b)
  );

  assign freq_level_flag_a = det_a.flag;
  assign freq_level_flag_b = det_b.flag;

  // apb: zero wait states
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign pslverr = psel && penable && !addr_ok;

  always_comb
  begin
    if (paddr == fldb_pkg::OFF_LEVEL_A)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_LAG_A)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_LEVEL_B)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_LAG_B)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_REACH_W)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_BRAKE_EN)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_BRAKE_THR)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_MAX_FREQ)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_VCLASS)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_STATUS)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_INT_STAT)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_INT_EN)
      addr_ok = 1'b1;
    else if (paddr == fldb_pkg::OFF_INT_CLR)
      addr_ok = 1'b1;
    else
      addr_ok = 1'b0;
  end

  // write limiting: out-of-range values are clamped rather than refused
  assign wr_freq     = pwdata[FW-1:0];
  // limits compare the whole word, so set upper bits cannot wrap a value into range
  assign wr_freq_lim = (pwdata > 32'(max_output_freq_setting_r)) ?
                       max_output_freq_setting_r : wr_freq; // RULE4
  assign wr_pct_lim  = (pwdata > 32'(fldb_pkg::LAG_MAX)) ?
                       fldb_pkg::LAG_MAX : pwdata[PW-1:0]; // RULE3
  assign wr_volt     = pwdata[VW-1:0];
  assign wr_volt_lim = (pwdata < 32'(fldb_pkg::THR_MIN)) ? fldb_pkg::THR_MIN :
                       (pwdata > 32'(fldb_pkg::THR_MAX)) ? fldb_pkg::THR_MAX : wr_volt; // RULE7

  always_comb
  begin
    case (vclass_r)
      fldb_pkg::FLDB_CLASS_220: class_thr = fldb_pkg::THR_220; // RULE8
      fldb_pkg::FLDB_CLASS_660: class_thr = fldb_pkg::THR_660;
      default:                  class_thr = fldb_pkg::THR_380;
    endcase
  end

  // until software writes a threshold, the class default is in force
  assign eff_thr = thr_touched_r ? brake_threshold_setting_r : class_thr; // RULE8

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_a_setting_r         <= fldb_pkg::LEVEL_DEF;
      lag_a_setting_r           <= fldb_pkg::LAG_DEF;
      level_b_setting_r         <= fldb_pkg::LEVEL_DEF; // RULE5
      lag_b_setting_r           <= fldb_pkg::LAG_DEF;
      reached_width_setting_r   <= fldb_pkg::REACH_DEF;
      brake_enable_setting_r    <= 1'b0;
      brake_threshold_setting_r <= fldb_pkg::THR_380;
      thr_touched_r             <= 1'b0;
      max_output_freq_setting_r <= fldb_pkg::MAX_FREQ_DEF;
      vclass_r                  <= fldb_pkg::FLDB_CLASS_380;
      int_en_r                  <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == fldb_pkg::OFF_LEVEL_A)
        level_a_setting_r <= wr_freq_lim; // RULE4
      else if (paddr == fldb_pkg::OFF_LAG_A)
        lag_a_setting_r <= wr_pct_lim;
      else if (paddr == fldb_pkg::OFF_LEVEL_B)
        level_b_setting_r <= wr_freq_lim;
      else if (paddr == fldb_pkg::OFF_LAG_B)
        lag_b_setting_r <= wr_pct_lim;
      else if (paddr == fldb_pkg::OFF_REACH_W)
        reached_width_setting_r <= wr_freq_lim; // RULE6
      else if (paddr == fldb_pkg::OFF_BRAKE_EN)
        brake_enable_setting_r <= pwdata[0];
      else if (paddr == fldb_pkg::OFF_BRAKE_THR)
      begin
        brake_threshold_setting_r <= wr_volt_lim;
        thr_touched_r             <= 1'b1;
      end
      else if (paddr == fldb_pkg::OFF_MAX_FREQ)
        max_output_freq_setting_r <= wr_freq;
      else if (paddr == fldb_pkg::OFF_VCLASS)
        vclass_r <= (pwdata[1:0] == 2'h3) ? 2'h1 : pwdata[1:0];
      else if (paddr == fldb_pkg::OFF_INT_EN)
        int_en_r <= pwdata[fldb_pkg::N_EVT-1:0];
    end
  end

  // frequency reached window around the set frequency
  assign reach_hi = {1'b0, set_freq_s} + {1'b0, reached_width_setting_r};
  assign reach_lo = (set_freq_s > reached_width_setting_r) ?
                    set_freq_s - reached_width_setting_r : '0;
  assign freq_reached_nxt = ({1'b0, out_freq_s} <= reach_hi) &&
                            (out_freq_s >= reach_lo); // RULE6
  assign brake_nxt = brake_enable_setting_r && (bus_volt_s >= eff_thr); // RULE7

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_reached_flag <= 1'b0;
      brake_on          <= 1'b0;
    end
    else
    begin
      freq_reached_flag <= freq_reached_nxt; // RULE9
      brake_on          <= brake_nxt; // RULE9
    end
  end

  // interrupts on rising edges of each flag; a new event beats a same-cycle clear
  assign flags = {brake_on, freq_reached_flag, det_b.flag, det_a.flag};
  assign evt_rise = flags & ~flags_prev_r;
  assign clr_mask = (wr_en && paddr == fldb_pkg::OFF_INT_CLR) ?
                    pwdata[fldb_pkg::N_EVT-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_prev_r <= '0;
      int_stat_r   <= '0;
    end
    else
    begin
      flags_prev_r <= flags;
      int_stat_r   <= (int_stat_r & ~clr_mask) | evt_rise;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |((int_stat_r & ~clr_mask | evt_rise) & int_en_r);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd_en && !penable)
    begin
      if (paddr == fldb_pkg::OFF_LEVEL_A)
        prdata <= 32'(level_a_setting_r);
      else if (paddr == fldb_pkg::OFF_LAG_A)
        prdata <= 32'(lag_a_setting_r);
      else if (paddr == fldb_pkg::OFF_LEVEL_B)
        prdata <= 32'(level_b_setting_r);
      else if (paddr == fldb_pkg::OFF_LAG_B)
        prdata <= 32'(lag_b_setting_r);
      else if (paddr == fldb_pkg::OFF_REACH_W)
        prdata <= 32'(reached_width_setting_r);
      else if (paddr == fldb_pkg::OFF_BRAKE_EN)
        prdata <= 32'(brake_enable_setting_r);
      else if (paddr == fldb_pkg::OFF_BRAKE_THR)
        prdata <= 32'(eff_thr);
      else if (paddr == fldb_pkg::OFF_MAX_FREQ)
        prdata <= 32'(max_output_freq_setting_r);
      else if (paddr == fldb_pkg::OFF_VCLASS)
        prdata <= 32'(vclass_r);
      else if (paddr == fldb_pkg::OFF_STATUS)
        prdata <= 32'(flags);
      else if (paddr == fldb_pkg::OFF_INT_STAT)
        prdata <= 32'(int_stat_r);
      else if (paddr == fldb_pkg::OFF_INT_EN)
        prdata <= 32'(int_en_r);
      else
        prdata <= '0;
    end
  end
endmodule

// ===== verification/fldb_plant.sv
// partner: drive plant presenting frequencies and bus voltage to the block
`timescale 1ns/10ps
module fldb_plant (
  input  wire logic        pclk,
  input  wire logic [15:0] of_cmd,
  input  wire logic [15:0] sf_cmd,
  input  wire logic [15:0] bv_cmd,
  output logic      [15:0] out_freq,
  output logic      [15:0] set_freq,
  output logic      [15:0] bus_volt
);
  // measurements change on a clock edge only, as a sampled plant would
  always_ff @(posedge pclk)
  begin
    out_freq <= of_cmd;
    set_freq <= sf_cmd;
    bus_volt <= bv_cmd;
  end
endmodule

// ===== verification/fldb_chk.sv
// checker: port level assertions for the level detect and brake block
`timescale 1ns/10ps
module fldb_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] bus_volt,
  input wire logic        freq_level_flag_a,
  input wire logic        freq_level_flag_b,
  input wire logic        brake_on,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_high_a: assert property (pready) else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  slverr_unmap_a: assert property (psel && penable && paddr > 8'h30 |-> pslverr)
    else $error("unmapped access not flagged");
  slverr_mapped_a: assert property (psel && penable && paddr <= 8'h30 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access flagged");
  slverr_misalign_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not flagged");
  read_unmap_a: assert property (psel && penable && !pwrite && paddr > 8'h30
    |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  read_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  brake_volt_a: assert property (brake_on |-> $past(bus_volt, 5) >= 16'h07D0
    || $past(bus_volt, 6) >= 16'h07D0) else $error("brake below minimum threshold");
  flag_a_rise_a: assert property ($rose(freq_level_flag_a) |-> $past(out_freq, 5) != 0
    || $past(out_freq, 6) != 0) else $error("flag a rose at zero frequency");
  flag_b_rise_a: assert property ($rose(freq_level_flag_b) |-> $past(out_freq, 5) != 0
    || $past(out_freq, 6) != 0) else $error("flag b rose at zero frequency");
  cover property ($rose(brake_on));
  cover property ($fell(freq_level_flag_a));
  cover property ($rose(irq));
endmodule
bind fldb_top fldb_chk fldb_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_freq(out_freq), .bus_volt(bus_volt), .brake_on(brake_on),
  .freq_level_flag_a(freq_level_flag_a), .freq_level_flag_b(freq_level_flag_b), .irq(irq));

// ===== verification/tb_fldb_top.sv
// testbench: registers, detectors, reached, brake and interrupts against a model
`timescale 1ns/10ps
module tb_fldb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] of_cmd = 16'h0000;
  logic [15:0] sf_cmd = 16'h0000;
  logic [15:0] bv_cmd = 16'h0000;
  logic [31:0] prdata, rd;
  logic [15:0] out_freq, set_freq, bus_volt;
  logic        pready, pslverr, err, fa, fb, rch, brk, irq;
  int fails = 0;
  int checks = 0;
  int la = 5000, ga = 50, lb = 5000, gb = 50, wid = 0, thr = 7000, ben = 0, ien = 0;
  int m_fa = 0, m_fb = 0, m_rc = 0, m_bk = 0, m_is = 0, v;
  int rv[9] = '{5000, 50, 5000, 50, 0, 0, 7000, 5000, 1};
  int cls[4] = '{3800, 7000, 11200, 7000};
  int wa[8] = '{0, 4, 8, 12, 16, 24, 20, 44};
  int wv[8] = '{4000, 100, 2000, 0, 100, 7000, 1, 15};
  int fl[10] = '{4000, 4001, 3700, 3600, 3599, 4001, 2000, 2001, 1999, 0};
  fldb_plant fldb_plant_i (.pclk(pclk), .of_cmd(of_cmd), .sf_cmd(sf_cmd), .bv_cmd(bv_cmd),
    .out_freq(out_freq), .set_freq(set_freq), .bus_volt(bus_volt));
  fldb_top fldb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_freq(out_freq), .set_freq(set_freq), .bus_volt(bus_volt),
    .freq_level_flag_a(fa), .freq_level_flag_b(fb), .freq_reached_flag(rch),
    .brake_on(brk), .irq(irq));
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one idle edge first, so a release is never overwritten in the same step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
    begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic step(input int f, input int s, input int b);
    int pa, pb, pr, pk;
    pa = m_fa;
    pb = m_fb;
    pr = m_rc;
    pk = m_bk;
    of_cmd <= 16'(f);
    sf_cmd <= 16'(s);
    bv_cmd <= 16'(b);
    repeat (10) @(posedge pclk);
    if (f > la) m_fa = 1; else if (f < la - la * ga / 1000) m_fa = 0;
    if (f > lb) m_fb = 1; else if (f < lb - lb * gb / 1000) m_fb = 0;
    m_rc = int'(f >= (s > wid ? s - wid : 0) && f <= s + wid);
    m_bk = int'(ben != 0 && b >= thr);
    m_is |= int'(m_fa > pa) | int'(m_fb > pb) << 1 | int'(m_rc > pr) << 2 | int'(m_bk > pk) << 3;
    chk({irq, brk, rch, fb, fa}, {(m_is & ien) != 0, m_bk[0], m_rc[0], m_fb[0], m_fa[0]});
    rchk(8'h24, 32'(m_bk * 8 + m_rc * 4 + m_fb * 2 + m_fa));
    rchk(8'h28, 32'(m_is));
  endtask
  initial
  begin
    v = $urandom(32'h93f4_9c2b);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rv[i]) rchk(8'(4 * i), 32'(rv[i]));
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
    foreach (cls[i])
    begin
      apb(1'b1, 8'h20, 32'(i));
      rchk(8'h18, 32'(cls[i]));
    end
    rchk(8'h20, 32'h1);
    apb(1'b1, 8'h00, 32'd6000);
    rchk(8'h00, 32'd5000);
    apb(1'b1, 8'h1C, 32'd3000);
    apb(1'b1, 8'h08, 32'd4000);
    rchk(8'h08, 32'd3000);
    rchk(8'h1C, 32'd3000);
    apb(1'b1, 8'h1C, 32'd5000);
    apb(1'b1, 8'h00, 32'h0001_0064);
    rchk(8'h00, 32'd5000);
    apb(1'b1, 8'h04, 32'd1200);
    rchk(8'h04, 32'd1000);
    apb(1'b1, 8'h18, 32'd100);
    rchk(8'h18, 32'd2000);
    apb(1'b1, 8'h18, 32'd30000);
    rchk(8'h18, 32'd20000);
    apb(1'b1, 8'h24, 32'h0000_000f);
    rchk(8'h24, 32'h0000_0004);
    foreach (wa[i]) apb(1'b1, 8'(wa[i]), 32'(wv[i]));
    la = 4000; ga = 100; lb = 2000; gb = 0; wid = 100; ben = 1; ien = 15;
    step(0, 0, 0);
    foreach (fl[i]) step(fl[i], 3700, i % 2 ? 7000 : 6999);
    repeat (16) step($urandom_range(5000), $urandom_range(5000), $urandom_range(8000));
    apb(1'b1, 8'h30, 32'h0000_000f);
    m_is = 0;
    step(0, 0, 0);
    apb(1'b1, 8'h2C, 32'h0000_0000);
    ien = 0;
    step(4500, 0, 8000);
    apb(1'b1, 8'h14, 32'h0000_0000);
    ben = 0;
    step(0, 0, 9000);
    complete_run();
  end
endmodule
